// File: hdl/event_unit.sv
// Function
// - sync event after all earlier inbound writes
// - any written value starts a sync request
// - software acks sync once before enabling
// - writing one to ack clears pending
// - handler: save mask, mask, ack, act, restore
// - common handler masks and acks in one write
// - attention bit write raises event when enabled
// - attention event carries only one bit
// - load-reserve marks line reserved, snoop clears
// - outside modification raises lost event if enabled
// - local clearing never raises lost event
// - other agents' writes lose the reservation
// - handler may reissue load-reserve, no status read
// - avoid reserve loops over four lines
// - use sync for cumulative multi-source ordering
// - sync bit 19, attention 20, lost 21
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module event_unit
  import ev_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  evt_if.device ch,
  output logic sync_busy,
  output logic reservation_held,
  output logic [OUT_CNT_W-1:0] inbound_outstanding
);

  // event mask, only the three implemented bits are stored
  logic [NUM_EVT-1:0] mask_reg;
  logic [NUM_EVT-1:0] mask_next;

  // inbound write tracking
  logic [OUT_CNT_W-1:0] out_cnt_reg;
  logic [OUT_CNT_W-1:0] out_cnt_next;
  logic [OUT_CNT_W-1:0] wait_cnt_reg;
  logic [OUT_CNT_W-1:0] wait_cnt_next;
  // waiting state of a sync request
  typedef enum logic [0:0] {
    SYNC_IDLE = 1'b0,
    SYNC_WAIT = 1'b1
  } sync_state_t;
  sync_state_t sync_state_reg;
  sync_state_t sync_state_next;
  logic [OUT_CNT_W-1:0] snapshot;

  // reservation state
  logic res_valid_reg;
  logic res_valid_next;
  logic [LINE_W-1:0] res_line_reg;
  logic [LINE_W-1:0] res_line_next;
  logic snoop_hit;
  logic same_line;

  // event sources and latches
  logic ms_set;
  logic attn_set;
  logic lr_set;
  logic [NUM_EVT-1:0] evt_set;
  logic [NUM_EVT-1:0] evt_clear;
  logic [NUM_EVT-1:0] pending;

  always_comb begin
    mask_next = mask_reg;
    if (ch.mask_wr) begin
      for (int i = 0; i < NUM_EVT; i++) begin
        mask_next[i] = ch.mask_data[EVT_BIT[i]];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mask_reg <= MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // completions are assumed to retire in start order, so the count of
  // writes still open at the request is exactly the set to wait for
  always_comb begin
    out_cnt_next = out_cnt_reg;
    unique case ({ch.inbound_start, ch.inbound_done})
      2'b10: out_cnt_next = out_cnt_reg + CNT_ONE;
      2'b01: out_cnt_next = out_cnt_reg - CNT_ONE;
      2'b00, 2'b11: out_cnt_next = out_cnt_reg;
    endcase
  end

  always_comb begin
    // a write started in the request cycle is not before it
    snapshot = ch.inbound_done ? out_cnt_reg - CNT_ONE : out_cnt_reg;
    wait_cnt_next = wait_cnt_reg;
    sync_state_next = sync_state_reg;
    ms_set = 1'b0;
    unique case (sync_state_reg)
      SYNC_IDLE: sync_state_next = SYNC_IDLE;
      SYNC_WAIT: begin
        if (ch.inbound_done) begin
          wait_cnt_next = wait_cnt_reg - CNT_ONE;
          if (wait_cnt_reg == CNT_ONE) begin
            ms_set = 1'b1;
            sync_state_next = SYNC_IDLE;
          end
        end
      end
    endcase
    // a new request restarts the wait; an old one ending now still fires
    if (ch.sync_req_wr) begin
      // the written value is ignored: any value is a request
      wait_cnt_next = snapshot;
      sync_state_next = (snapshot != CNT_ZERO) ? SYNC_WAIT : SYNC_IDLE;
      if (snapshot == CNT_ZERO) begin
        ms_set = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      out_cnt_reg <= CNT_ZERO;
      wait_cnt_reg <= CNT_ZERO;
      sync_state_reg <= SYNC_IDLE;
    end else begin
      out_cnt_reg <= out_cnt_next;
      wait_cnt_reg <= wait_cnt_next;
      sync_state_reg <= sync_state_next;
    end
  end

  // attention: a single occurrence bit, nothing else is carried
  always_comb begin
    attn_set = ch.attn_wr & ch.attn_data & mask_reg[IDX_ATTN];
  end

  // only the line number is kept, so any byte of the line matches
  assign same_line = (ch.snoop_addr[31:LINE_LSB] == res_line_reg);

  always_comb begin
    snoop_hit = ch.snoop_wr && res_valid_reg && same_line;
    res_valid_next = res_valid_reg;
    res_line_next = res_line_reg;
    lr_set = 1'b0;
    if (ch.reserve_cmd) begin
      // a fresh reservation replaces any loss seen in the same cycle
      res_valid_next = 1'b1;
      res_line_next = ch.reserve_addr[31:LINE_LSB];
    end else if (ch.local_store) begin
      // a local store ends the reservation without any event
      res_valid_next = 1'b0;
    end else if (snoop_hit) begin
      res_valid_next = 1'b0;
      lr_set = mask_reg[IDX_LR];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      res_valid_reg <= 1'b0;
      res_line_reg <= '0;
    end else begin
      res_valid_reg <= res_valid_next;
      res_line_reg <= res_line_next;
    end
  end

  // each source drives its own bit, one process per vector
  always_comb begin
    evt_set = PEND_RESET;
    evt_set[IDX_MS] = ms_set;
    evt_set[IDX_ATTN] = attn_set;
    evt_set[IDX_LR] = lr_set;
  end

  // one sticky latch per source; the acknowledge word picks the clears
  generate
    for (genvar g = 0; g < NUM_EVT; g++) begin : g_evt
      assign evt_clear[g] = ch.ack_wr & ch.ack_data[EVT_BIT[g]];
      event_latch event_latch_inst (
        .ref_clk(ref_clk),
        .reset(reset),
        .set(evt_set[g]),
        .clear(evt_clear[g]),
        .pending(pending[g])
      );
    end
  endgenerate

  // unimplemented bits read as zero
  always_comb begin
    ch.status_data = WORD_RESET;
    ch.mask_rd_data = WORD_RESET;
    for (int i = 0; i < NUM_EVT; i++) begin
      ch.status_data[EVT_BIT[i]] = pending[i] & mask_reg[i];
      ch.mask_rd_data[EVT_BIT[i]] = mask_reg[i];
    end
  end

  // user-side views, all straight from flops
  assign ch.res_valid = res_valid_reg;
  assign sync_busy = (sync_state_reg == SYNC_WAIT);
  assign reservation_held = res_valid_reg;
  assign inbound_outstanding = out_cnt_reg;

endmodule
`default_nettype wire

// File: hdl/ev_pkg.sv
package ev_pkg;
  // bit positions inside the status, mask and acknowledge words
  localparam int NUM_EVT = 3;
  localparam int EVT_MS_BIT = 19;
  localparam int EVT_ATTN_BIT = 20;
  localparam int EVT_LR_BIT = 21;
  localparam int EVT_BIT [NUM_EVT] = '{EVT_MS_BIT, EVT_ATTN_BIT, EVT_LR_BIT};
  // index of each event in the three-bit internal vectors
  localparam int IDX_MS = 0;
  localparam int IDX_ATTN = 1;
  localparam int IDX_LR = 2;
  localparam logic [NUM_EVT-1:0] MASK_RESET = 3'h0;
  localparam logic [NUM_EVT-1:0] PEND_RESET = 3'h0;
  // channel number of the sync request channel, kept for software views
  localparam int SYNC_CHANNEL_NUM = 9;
  localparam logic [31:0] SYNC_REQ_VALUE = 32'h0000_0000;
  // reservation granule is a 128-byte line
  localparam int LINE_BYTES = 128;
  localparam int LINE_LSB = $clog2(LINE_BYTES);
  localparam int LINE_W = 32 - LINE_LSB;
  localparam int OUT_CNT_W = 8;
  localparam logic [OUT_CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [OUT_CNT_W-1:0] CNT_ONE = 8'h01;
  // controller register offsets on the apb side
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_RES_ADDR = 8'h04;
  localparam logic [7:0] OFS_MASK_WR = 8'h08;
  localparam logic [7:0] OFS_ACK_WR = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK_RD = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
  localparam int CMD_SYNC = 0;
  localparam int CMD_ATTN = 1;
  localparam int CMD_RESERVE = 2;
  localparam int CMD_LOCAL_STORE = 3;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
endpackage

// File: hdl/evt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface evt_if;
  logic sync_req_wr;
  logic [31:0] sync_req_data;
  logic mask_wr;
  logic [31:0] mask_data;
  logic ack_wr;
  logic [31:0] ack_data;
  logic attn_wr;
  logic attn_data;
  logic reserve_cmd;
  logic [31:0] reserve_addr;
  logic local_store;
  logic snoop_wr;
  logic [31:0] snoop_addr;
  logic inbound_start;
  logic inbound_done;
  logic [31:0] status_data;
  logic [31:0] mask_rd_data;
  logic res_valid;

  modport device (
    input sync_req_wr, sync_req_data, mask_wr, mask_data, ack_wr, ack_data,
    input attn_wr, attn_data, reserve_cmd, reserve_addr, local_store,
    input snoop_wr, snoop_addr, inbound_start, inbound_done,
    output status_data, mask_rd_data, res_valid
  );
  modport host (
    output sync_req_wr, sync_req_data, mask_wr, mask_data, ack_wr, ack_data,
    output attn_wr, attn_data, reserve_cmd, reserve_addr, local_store,
    output snoop_wr, snoop_addr, inbound_start, inbound_done,
    input status_data, mask_rd_data, res_valid
  );
endinterface
`default_nettype wire

// File: hdl/event_latch.sv
`timescale 1ns/1ns
`default_nettype none
module event_latch (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic set,
  input wire logic clear,
  output logic pending
);
  logic pend_reg;
  logic pend_next;

  // a set in the clearing cycle wins, so no occurrence is dropped
  always_comb begin
    pend_next = pend_reg;
    if (clear) begin
      pend_next = 1'b0;
    end
    if (set) begin
      pend_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  assign pending = pend_reg;
endmodule
`default_nettype wire

// File: hdl/event_host.sv
`timescale 1ns/1ns
`default_nettype none
module event_host
  import ev_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  evt_if.host ch,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_snoop_wr,
  input wire logic [31:0] ext_snoop_addr,
  input wire logic ext_inbound_start,
  input wire logic ext_inbound_done,
  output logic irq
);
  logic wr_acc;
  logic setup;
  logic mapped;
  logic [31:0] cmd_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [31:0] res_addr_reg, res_addr_next;
  logic [31:0] mask_data_reg, mask_data_next;
  logic [31:0] ack_data_reg, ack_data_next;
  logic sync_reg, attn_reg, reserve_reg, local_reg;
  logic mask_wr_reg, mask_wr_next, ack_wr_reg, ack_wr_next;
  logic [NUM_EVT-1:0] stat_now, stat_prev_reg;
  logic [NUM_EVT-1:0] irq_stat_reg, irq_stat_next;
  logic [NUM_EVT-1:0] irq_mask_reg, irq_mask_next;

  assign wr_acc = psel & penable & pwrite;
  assign setup = psel & ~penable;

  always_comb begin
    unique case (paddr)
      OFS_CMD, OFS_RES_ADDR, OFS_MASK_WR, OFS_ACK_WR, OFS_STATUS,
      OFS_MASK_RD, OFS_IRQ_STAT, OFS_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // read data is latched in the setup cycle so prdata comes from a flop
  always_comb begin
    prdata_next = prdata_reg;
    if (setup) begin
      prdata_next = WORD_RESET;
      unique case (paddr)
        OFS_RES_ADDR: prdata_next = res_addr_reg;
        OFS_STATUS: prdata_next = ch.status_data;
        OFS_MASK_RD: prdata_next = ch.mask_rd_data;
        default: prdata_next = WORD_RESET;
      endcase
      for (int i = 0; i < NUM_EVT; i++) begin
        if (paddr == OFS_IRQ_STAT) prdata_next[EVT_BIT[i]] = irq_stat_reg[i];
        if (paddr == OFS_IRQ_MASK) prdata_next[EVT_BIT[i]] = irq_mask_reg[i];
      end
    end
  end

  always_comb begin
    cmd_next = (wr_acc && paddr == OFS_CMD) ? pwdata : WORD_RESET;
    res_addr_next = res_addr_reg;
    if (wr_acc && paddr == OFS_RES_ADDR) res_addr_next = pwdata;
    mask_wr_next = wr_acc && paddr == OFS_MASK_WR;
    mask_data_next = mask_wr_next ? pwdata : mask_data_reg;
    ack_wr_next = wr_acc && paddr == OFS_ACK_WR;
    ack_data_next = ack_wr_next ? pwdata : ack_data_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    for (int i = 0; i < NUM_EVT; i++) begin
      stat_now[i] = ch.status_data[EVT_BIT[i]];
      if (wr_acc && paddr == OFS_IRQ_MASK) begin
        irq_mask_next[i] = pwdata[EVT_BIT[i]];
      end
      if (wr_acc && paddr == OFS_IRQ_STAT && pwdata[EVT_BIT[i]]) begin
        irq_stat_next[i] = 1'b0;
      end
      // rising status sets the sticky bit, winning over a clear
      if (stat_now[i] && !stat_prev_reg[i]) irq_stat_next[i] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata_reg <= WORD_RESET;
      res_addr_reg <= WORD_RESET;
      mask_data_reg <= WORD_RESET;
      ack_data_reg <= WORD_RESET;
      mask_wr_reg <= 1'b0;
      ack_wr_reg <= 1'b0;
      sync_reg <= 1'b0;
      attn_reg <= 1'b0;
      reserve_reg <= 1'b0;
      local_reg <= 1'b0;
      stat_prev_reg <= PEND_RESET;
      irq_stat_reg <= PEND_RESET;
      irq_mask_reg <= MASK_RESET;
    end else begin
      prdata_reg <= prdata_next;
      res_addr_reg <= res_addr_next;
      mask_data_reg <= mask_data_next;
      ack_data_reg <= ack_data_next;
      mask_wr_reg <= mask_wr_next;
      ack_wr_reg <= ack_wr_next;
      sync_reg <= cmd_next[CMD_SYNC];
      attn_reg <= cmd_next[CMD_ATTN];
      reserve_reg <= cmd_next[CMD_RESERVE];
      local_reg <= cmd_next[CMD_LOCAL_STORE];
      stat_prev_reg <= stat_now;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  assign ch.sync_req_wr = sync_reg;
  assign ch.sync_req_data = SYNC_REQ_VALUE;
  assign ch.attn_wr = attn_reg;
  assign ch.attn_data = 1'b1;
  assign ch.reserve_cmd = reserve_reg;
  assign ch.reserve_addr = res_addr_reg;
  assign ch.local_store = local_reg;
  assign ch.mask_wr = mask_wr_reg;
  assign ch.mask_data = mask_data_reg;
  assign ch.ack_wr = ack_wr_reg;
  assign ch.ack_data = ack_data_reg;
  // outside agents reach the device unchanged; no reordering here
  assign ch.snoop_wr = ext_snoop_wr;
  assign ch.snoop_addr = ext_snoop_addr;
  assign ch.inbound_start = ext_inbound_start;
  assign ch.inbound_done = ext_inbound_done;
  assign prdata = prdata_reg;
  assign pready = penable;
  assign pslverr = psel & penable & ~mapped;
  assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule
`default_nettype wire

// File: testbench/evt_properties.sv
`timescale 1ns/1ns
`default_nettype none
module evt_properties
  import ev_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sync_req_wr,
  input wire logic mask_wr,
  input wire logic [31:0] mask_data,
  input wire logic ack_wr,
  input wire logic [31:0] ack_data,
  input wire logic attn_wr,
  input wire logic attn_data,
  input wire logic reserve_cmd,
  input wire logic [31:0] reserve_addr,
  input wire logic local_store,
  input wire logic snoop_wr,
  input wire logic [31:0] snoop_addr,
  input wire logic inbound_start,
  input wire logic inbound_done,
  input wire logic [31:0] status_data,
  input wire logic [31:0] mask_rd_data,
  input wire logic res_valid
);
  localparam logic [31:0] EV = 32'h0038_0000;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [7:0] open_reg;
  logic [31:0] line_reg;
  logic hit;
  // own count of open inbound writes, kept apart from the design's counter
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      open_reg <= 8'h00;
      line_reg <= 32'h0000_0000;
    end else begin
      open_reg <= open_reg + {7'h00, inbound_start} - {7'h00, inbound_done};
      if (reserve_cmd) line_reg <= reserve_addr;
    end
  end
  assign hit = snoop_wr && res_valid &&
    (snoop_addr[31:LINE_LSB] == line_reg[31:LINE_LSB]);
  property p_sync_now;
    sync_req_wr && open_reg == 8'h00 && mask_rd_data[EVT_MS_BIT] && !mask_wr
      && !ack_wr |=> status_data[EVT_MS_BIT];
  endproperty
  property p_sync_wait;
    sync_req_wr && open_reg > {7'h00, inbound_done} && !mask_wr &&
      mask_rd_data[EVT_MS_BIT] && !status_data[EVT_MS_BIT]
      |=> !status_data[EVT_MS_BIT];
  endproperty
  property p_attn;
    attn_wr && attn_data && mask_rd_data[EVT_ATTN_BIT] && !mask_wr
      |=> status_data[EVT_ATTN_BIT];
  endproperty
  property p_ack;
    ack_wr && ack_data[EVT_ATTN_BIT] && !attn_wr
      |=> !status_data[EVT_ATTN_BIT];
  endproperty
  property p_reserve;
    reserve_cmd |=> res_valid;
  endproperty
  property p_lost;
    hit && !local_store && !reserve_cmd && mask_rd_data[EVT_LR_BIT] &&
      !mask_wr ##1 1'b1 |-> status_data[EVT_LR_BIT] && !res_valid;
  endproperty
  property p_local;
    local_store && !reserve_cmd && !mask_wr && !status_data[EVT_LR_BIT]
      |=> !res_valid && !status_data[EVT_LR_BIT];
  endproperty
  property p_mask;
    mask_wr |=> mask_rd_data == (mask_data & EV);
  endproperty
  property p_layout;
    (status_data & ~(mask_rd_data & EV)) == 32'h0000_0000;
  endproperty
  a_sync_now: assert property (p_sync_now) else $error("sync late");
  a_sync_wait: assert property (p_sync_wait) else $error("sync soon");
  a_attn: assert property (p_attn) else $error("no attention");
  a_ack: assert property (p_ack) else $error("ack ignored");
  a_reserve: assert property (p_reserve) else $error("no reserve");
  a_lost: assert property (p_lost) else $error("no lost event");
  a_local: assert property (p_local) else $error("local loss seen");
  a_mask: assert property (p_mask) else $error("mask bits off");
  a_layout: assert property (p_layout) else $error("status bad");
  c_attn: cover property (attn_wr ##1 status_data[EVT_ATTN_BIT]);
  c_lost: cover property (hit ##1 status_data[EVT_LR_BIT]);
  c_wait: cover property (sync_req_wr && open_reg > 8'h01);
endmodule
`default_nettype wire

// File: testbench/tb_sync_attention_reservation_events.sv
`timescale 1ns/1ns
`default_nettype none
module tb_sync_attention_reservation_events;
  import ev_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, sa = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, busy, held, err;
  logic sw = 1'b0, ist = 1'b0, idn = 1'b0;
  logic [OUT_CNT_W-1:0] outst;
  int fail_count = 0, checks_done = 0, cyc = 0;
  evt_if ch();
  event_unit event_unit_inst(.ref_clk(ref_clk), .reset(reset), .ch(ch),
    .sync_busy(busy), .reservation_held(held), .inbound_outstanding(outst));
  event_host event_host_inst(.ref_clk(ref_clk), .reset(reset), .ch(ch),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_snoop_wr(sw), .ext_snoop_addr(sa), .ext_inbound_start(ist),
    .ext_inbound_done(idn), .irq(irq));
  evt_properties evt_properties_inst(.ref_clk(ref_clk), .reset(reset),
    .sync_req_wr(ch.sync_req_wr), .mask_wr(ch.mask_wr),
    .mask_data(ch.mask_data), .ack_wr(ch.ack_wr), .ack_data(ch.ack_data),
    .attn_wr(ch.attn_wr), .attn_data(ch.attn_data),
    .reserve_cmd(ch.reserve_cmd), .reserve_addr(ch.reserve_addr),
    .local_store(ch.local_store), .snoop_wr(ch.snoop_wr),
    .snoop_addr(ch.snoop_addr), .inbound_start(ch.inbound_start),
    .inbound_done(ch.inbound_done), .status_data(ch.status_data),
    .mask_rd_data(ch.mask_rd_data), .res_valid(ch.res_valid));
  always #5 ref_clk = ~ref_clk;
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // whole run needs under two hundred cycles, so this only catches a hang
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      test_done;
    end
  end
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // idle cycle after release keeps psel from being driven twice per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask
  task automatic ext(input logic s, input logic i, input logic o,
                     input logic [31:0] a);
    sw <= s;
    ist <= i;
    idn <= o;
    sa <= a;
    @(posedge ref_clk);
    sw <= 1'b0;
    ist <= 1'b0;
    idn <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic t_reset;
    rdc("mask", OFS_MASK_RD, 32'h0000_0000);
    rdc("status", OFS_STATUS, 32'h0000_0000);
    chk("irq", 32'h0, {31'h0, irq});
    rdc("unmapped", 8'h20, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, err});
    wr(OFS_MASK_WR, 32'hffff_ffff);
    rdc("mask all", OFS_MASK_RD, 32'h0038_0000);
  endtask
  task automatic t_attn;
    wr(OFS_MASK_WR, 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0002);
    wr(OFS_MASK_WR, 32'h0010_0000);
    rdc("attn masked", OFS_STATUS, 32'h0000_0000);
    wr(OFS_IRQ_MASK, 32'h0038_0000);
    wr(OFS_CMD, 32'h0000_0002);
    rdc("attn", OFS_STATUS, 32'h0010_0000);
    chk("attn irq", 32'h1, {31'h0, irq});
    wr(OFS_ACK_WR, 32'h0010_0000);
    rdc("attn ack", OFS_STATUS, 32'h0000_0000);
    wr(OFS_IRQ_STAT, 32'h0010_0000);
    chk("irq clear", 32'h0, {31'h0, irq});
  endtask
  task automatic t_lost;
    wr(OFS_MASK_WR, 32'h0020_0000);
    wr(OFS_RES_ADDR, 32'h0000_1000);
    wr(OFS_CMD, 32'h0000_0004);
    @(posedge ref_clk);
    chk("held", 32'h1, {31'h0, held});
    ext(1'b1, 1'b0, 1'b0, 32'h0000_0f80);
    chk("other line", 32'h1, {31'h0, held});
    ext(1'b1, 1'b0, 1'b0, 32'h0000_107c);
    chk("snooped", 32'h0, {31'h0, held});
    rdc("lost", OFS_STATUS, 32'h0020_0000);
    wr(OFS_ACK_WR, 32'h0020_0000);
    wr(OFS_CMD, 32'h0000_0004);
    wr(OFS_CMD, 32'h0000_0008);
    @(posedge ref_clk);
    chk("local", 32'h0, {31'h0, held});
    rdc("local quiet", OFS_STATUS, 32'h0000_0000);
    wr(OFS_MASK_WR, 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0004);
    ext(1'b1, 1'b0, 1'b0, 32'h0000_1000);
    wr(OFS_MASK_WR, 32'h0020_0000);
    rdc("lost masked", OFS_STATUS, 32'h0000_0000);
  endtask
  task automatic t_sync;
    wr(OFS_ACK_WR, 32'h0008_0000);
    wr(OFS_MASK_WR, 32'h0008_0000);
    ext(1'b0, 1'b1, 1'b0, 32'h0000_0000);
    ext(1'b0, 1'b1, 1'b0, 32'h0000_0000);
    chk("open", 32'h2, {24'h0, outst});
    wr(OFS_CMD, 32'h0000_0001);
    @(posedge ref_clk);
    chk("busy", 32'h1, {31'h0, busy});
    rdc("sync early", OFS_STATUS, 32'h0000_0000);
    ext(1'b0, 1'b0, 1'b1, 32'h0000_0000);
    rdc("sync one", OFS_STATUS, 32'h0000_0000);
    ext(1'b0, 1'b0, 1'b1, 32'h0000_0000);
    rdc("sync done", OFS_STATUS, 32'h0008_0000);
    wr(OFS_ACK_WR, 32'h0008_0000);
    wr(OFS_CMD, 32'h0000_0001);
    rdc("sync idle", OFS_STATUS, 32'h0008_0000);
  endtask
  // common handler: mask all in one write, ack all in one, then restore
  task automatic t_handler;
    wr(OFS_MASK_WR, 32'h0038_0000);
    wr(OFS_RES_ADDR, 32'h0000_2000);
    wr(OFS_CMD, 32'h0000_0006);
    ext(1'b1, 1'b0, 1'b0, 32'h0000_2040);
    rdc("all pending", OFS_STATUS, 32'h0038_0000);
    rdc("saved mask", OFS_MASK_RD, 32'h0038_0000);
    wr(OFS_MASK_WR, 32'h0000_0000);
    rdc("all masked", OFS_STATUS, 32'h0000_0000);
    wr(OFS_ACK_WR, 32'h0038_0000);
    wr(OFS_MASK_WR, 32'h0038_0000);
    rdc("restored", OFS_STATUS, 32'h0000_0000);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_attn;
    t_lost;
    t_sync;
    t_handler;
    test_done;
  end
endmodule
`default_nettype wire
